// ### sfpi_defines.svh
// timing counts and encodings for the serial flash pin interface
`ifndef SFPI_DEFINES_SVH
`define SFPI_DEFINES_SVH
`define SFPI_BYTE_BITS      4'h8
`define SFPI_BIT_CNT_RST    3'h0
`define SFPI_SCK_PERIOD_NS  80
`define SFPI_CLK_PERIOD_NS  10
`endif

// ### sfpi_pkg.sv
// types shared by the serial flash pin interface
package sfpi_pkg;
   typedef enum logic [4:0] {
      SFPI_IDLE = 5'b0_0001,
      SFPI_CMD  = 5'b0_0010,
      SFPI_ADDR = 5'b0_0100,
      SFPI_DATA = 5'b0_1000,
      SFPI_READ = 5'b1_0000
   } sfpi_state_t;

   typedef struct packed {
      logic       sck;
      logic       cs_n;
      logic       hold_n;
      logic       wp_n;
      logic [3:0] dq;
   } sfpi_pins_t;

   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } sfpi_drive_t;
endpackage : sfpi_pkg

// ### sfpi_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module sfpi_sync
#(
   parameter int W = 8
)
(
   input  wire logic         clk_sys, // system clock
   input  wire logic         rstn,    // async reset, active low
   input  wire logic [W-1:0] d,       // raw pin levels
   output logic      [W-1:0] q        // synchronised levels
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         // low after reset: a select held low from power-up shows no edge
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : sfpi_sync
`default_nettype wire

// ### sfpi_core.sv
// device-side pin logic of a serial flash interface
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_defines.svh"
//==========================================================
// Contract
// - capture serial input bits on rising serial clock edges.
// - launch output bits after falling serial clock edges.
// - select high deselects and floats output; low activates.
// - no command accepted before first select falling edge after power-up.
// - standby when deselected and no internal operation runs.
// - pause low floats output, ignores input and clock.
// - protect low rejects program/erase hitting protected area.
// - dual/quad modes use lines 0 and 1 bidirectionally.
// - quad mode uses pause and protect pins as data lines.
// - transfers are whole bytes, msb first.
// - stopped clock with select low is tolerated.
// - quad bit turns protect/pause pins into lines 2 and 3.
module sfpi_core
   import sfpi_pkg::*;
(
   input  wire logic       clk_sys,        // system clock 100 MHz
   input  wire logic       rstn,           // async reset, active low
   input  wire logic       sck,            // serial clock pin
   input  wire logic       cs_n,           // chip select, active low
   input  wire logic [3:0] dq_i,           // data line input levels
   output logic      [3:0] dq_o,           // data line output values
   output logic      [3:0] dq_oe,          // data line output enables
   input  wire logic       quad_en,        // non-volatile quad bit
   input  wire logic [1:0] xfer_width,     // 0 single, 1 dual, 2 quad
   input  wire logic       busy,           // internal operation running
   input  wire logic       protected_hit,  // target in protected area
   input  wire logic       read_phase,     // command now returns data
   input  wire logic       prog_cmd,       // command programs or erases
   input  wire logic [7:0] tx_byte,        // next byte to return
   output logic            byte_valid,     // one-cycle pulse: byte taken
   output logic      [7:0] rx_byte,        // captured byte
   output logic            tx_next,        // one-cycle pulse: load tx
   output logic            reject,         // one-cycle pulse: rejected
   output logic            armed,          // first select edge seen
   output logic            standby         // device in standby
);
   //==========================================================
   // pin synchronisers
   logic [5:0] raw;
   logic [5:0] syn;
   assign raw = {sck, cs_n, dq_i};

   sfpi_sync #(.W(6)) u_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d       (raw),
      .q       (syn)
   );

   logic       s_sck;
   logic       s_cs_n;
   logic [3:0] s_dq;
   logic       hold_n;
   logic       wp_n;
   assign s_sck  = syn[5];
   assign s_cs_n = syn[4];
   assign s_dq   = syn[3:0];
   // quad bit reassigns the control pins as data lines
   assign hold_n = quad_en ? 1'b1 : s_dq[3];
   assign wp_n   = quad_en ? 1'b1 : s_dq[2];

   //==========================================================
   // state
   typedef struct packed {
      sfpi_state_t st;
      logic        sck_d;
      logic        cs_d;
      logic        armed;
      logic [2:0]  bits;
      logic [7:0]  sh_in;
      logic [7:0]  sh_out;
      logic [3:0]  o;
      logic        drive;
      logic        bv;
      logic [7:0]  rx;
      logic        txn;
      logic        rej;
   } sfpi_reg_t;

   sfpi_reg_t r;
   sfpi_reg_t next_r;

   logic rise;
   logic fall;
   logic cs_fall;
   logic [2:0] step;
   assign rise    = s_sck & ~r.sck_d & hold_n;
   assign fall    = ~s_sck & r.sck_d & hold_n;
   assign cs_fall = ~s_cs_n & r.cs_d;
   assign step    = (xfer_width == 2'd2) ? 3'd4 :
                    (xfer_width == 2'd1) ? 3'd2 : 3'd1;

   always_comb
   begin
      next_r       = r;
      next_r.sck_d = s_sck;
      next_r.cs_d  = s_cs_n;
      next_r.bv    = 1'b0;
      next_r.txn   = 1'b0;
      next_r.rej   = 1'b0;
      if (cs_fall)
         next_r.armed = 1'b1;
      if (s_cs_n)
      begin
         next_r.st    = SFPI_IDLE;
         next_r.drive = 1'b0;
         next_r.bits  = `SFPI_BIT_CNT_RST;
      end
      else if (r.armed)
      begin
         if (r.st == SFPI_IDLE)
            next_r.st = SFPI_CMD;
         if (rise && !(read_phase && r.st != SFPI_CMD))
         begin
            // msb first, one to four lines per edge
            case (xfer_width)
               2'd1: next_r.sh_in = {r.sh_in[5:0], s_dq[1:0]};
               2'd2: next_r.sh_in = {r.sh_in[3:0], s_dq};
               default: next_r.sh_in = {r.sh_in[6:0], s_dq[0]};
            endcase
            next_r.bits = 3'(r.bits + step);
            if (3'(r.bits + step) == 3'd0)
            begin
               next_r.bv = 1'b1;
               next_r.rx = next_r.sh_in;
               if (r.st == SFPI_CMD)
                  next_r.st = SFPI_ADDR;
               if (prog_cmd && !wp_n && protected_hit)
                  next_r.rej = 1'b1;
            end
         end
         if (read_phase && r.st != SFPI_CMD)
         begin
            next_r.st = SFPI_READ;
            if (fall)
            begin
               if (r.bits == 3'd0)
                  next_r.sh_out = tx_byte;
               else
                  next_r.sh_out = r.sh_out << step;
               next_r.o = (r.bits == 3'd0) ? tx_byte[7:4] : next_r.sh_out[7:4];
               next_r.txn  = (r.bits == 3'd0);
               next_r.bits = 3'(r.bits + step);
               next_r.drive = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         r       <= '0;
         r.st    <= SFPI_IDLE;
         r.sck_d <= 1'b0;
         // matches the synchroniser's low reset level: no false select edge
         r.cs_d  <= 1'b0;
      end
      else
         r <= next_r;
   end

   //==========================================================
   // pin drive
   always_comb
   begin
      dq_o  = 4'h0;
      dq_oe = 4'h0;
      if (r.drive && !s_cs_n && hold_n)
      begin
         case (xfer_width)
            2'd1:
            begin
               dq_o  = {2'b00, r.o[3:2]};
               dq_oe = 4'b0011;
            end
            2'd2:
            begin
               dq_o  = r.o;
               dq_oe = quad_en ? 4'b1111 : 4'b0011;
            end
            default:
            begin
               dq_o  = {2'b00, r.o[3], 1'b0};
               dq_oe = 4'b0010;
            end
         endcase
      end
   end

   assign byte_valid = r.bv;
   assign rx_byte    = r.rx;
   assign tx_next    = r.txn;
   assign reject     = r.rej;
   assign armed      = r.armed;
   assign standby    = s_cs_n & ~busy;

   //==========================================================
   // checks
   a_float_deselect: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_cs_n |-> dq_oe == 4'h0) else $error("output driven while deselected");
   a_pause_float: assert property (@(posedge clk_sys) disable iff (!rstn)
      !hold_n |-> dq_oe == 4'h0) else $error("output driven in pause");
   a_no_cmd_early: assert property (@(posedge clk_sys) disable iff (!rstn)
      !r.armed |-> !r.bv) else $error("byte taken before select edge");
   a_arm_on_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
      cs_fall |=> r.armed) else $error("select edge not armed");
   a_standby_lvl: assert property (@(posedge clk_sys) disable iff (!rstn)
      (s_cs_n && !busy) |-> standby) else $error("standby missing");
   a_reject_prot: assert property (@(posedge clk_sys) disable iff (!rstn)
      r.rej |-> $past(prog_cmd && protected_hit && !wp_n))
      else $error("reject without cause");
   a_cmd_float: assert property (@(posedge clk_sys) disable iff (!rstn)
      (r.st == SFPI_CMD) |-> dq_oe == 4'h0) else $error("driven in command");
   a_quad_lines: assert property (@(posedge clk_sys) disable iff (!rstn)
      (dq_oe[3] || dq_oe[2]) |-> quad_en) else $error("quad lines misused");
   a_launch_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
      $changed(r.o) |-> $past(fall))
      else $error("output moved without a clock fall");
   a_capture_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
      $changed(r.rx) |-> $past(rise))
      else $error("byte taken without a clock rise");
endmodule : sfpi_core
`default_nettype wire

// ### sfpi_host.sv
// host-side serial master model for the pin interface bench
`timescale 1ns/1ns
`default_nettype none
module sfpi_host
(
   input  wire logic       clk_sys, // bench clock, paces the pins
   input  wire logic       so,      // resolved data line 1
   output logic            sck,     // serial clock, mode 0
   output logic            cs_n,    // chip select, active low
   output logic            hold_n,  // pause, active low
   output logic            wp_n,    // write protect, active low
   output logic            si,      // data line 0
   output logic      [7:0] got      // byte sampled from so
);
   initial
   begin
      sck    = 1'b0;
      cs_n   = 1'b1;
      hold_n = 1'b1;
      wp_n   = 1'b1;
      si     = 1'b0;
      got    = 8'h00;
   end
   task automatic half;
      repeat (4) @(negedge clk_sys);
   endtask : half
   task automatic frame(input logic on);
      half();
      cs_n <= !on;
      if (!on)
         si <= ~si; // released line shows no stale value
      half();
   endtask : frame
   // clock idles low and stands still outside frames
   task automatic xfer(input logic [7:0] b, input int pause_at);
      for (int i = 7; i >= 0; i--)
      begin
         si <= b[i];
         half();
         if (i == pause_at)
         begin
            hold_n <= 1'b0;
            half();
            sck <= 1'b1;
            half();
            sck <= 1'b0;
            half();
            hold_n <= 1'b1;
            half();
         end
         sck <= 1'b1;
         got <= {got[6:0], so};
         half();
         sck <= 1'b0;
      end
   endtask : xfer
endmodule : sfpi_host
`default_nettype wire

// ### tb_sfpi_core.sv
// self-checking bench for the serial flash pin interface
`timescale 1ns/1ns
`default_nettype none
module tb_sfpi_core;
   import sfpi_pkg::*;
   logic       clk_sys = 1'b0;
   logic       rstn = 1'b0;
   logic       quad_en;
   logic [1:0] xfer_width;
   logic       busy;
   logic       protected_hit;
   logic       read_phase;
   logic       prog_cmd;
   logic [7:0] tx_byte;
   logic       sck, cs_n, hold_n, wp_n, si, byte_valid, tx_next, reject;
   logic       armed, standby;
   logic [7:0] rx_byte, got;
   logic [3:0] dq_o, dq_oe;
   int         num_errors = 0, checks = 0, cycles = 0;
   int         n_bv = 0, n_rej = 0, n_bad = 0, n_txn = 0;
   logic [1:0] cs_hist = 2'b00;
   logic       so_last = 1'b0;
   logic [7:0] multi_got;
   logic [3:0] multi_oe;
   // a released line shows the inverse of its last driven level
   wire logic  so = dq_oe[1] ? dq_o[1] : ~so_last;
   always #5 clk_sys = ~clk_sys;
   sfpi_host sfpi_host_i (.clk_sys(clk_sys), .so(so), .sck(sck),
      .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n), .si(si), .got(got));
   sfpi_core sfpi_core_i (.clk_sys(clk_sys), .rstn(rstn), .sck(sck),
      .cs_n(cs_n), .dq_i({hold_n, wp_n, so, si}), .dq_o(dq_o),
      .dq_oe(dq_oe), .quad_en(quad_en), .xfer_width(xfer_width),
      .busy(busy), .protected_hit(protected_hit), .read_phase(read_phase),
      .prog_cmd(prog_cmd), .tx_byte(tx_byte), .byte_valid(byte_valid),
      .rx_byte(rx_byte), .tx_next(tx_next), .reject(reject),
      .armed(armed), .standby(standby));
   // pulses are counted at the edge where they stand
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (byte_valid === 1'b1)
         n_bv <= n_bv + 1;
      if (reject === 1'b1)
         n_rej <= n_rej + 1;
      if (tx_next === 1'b1)
         n_txn <= n_txn + 1;
      if (dq_oe[1] === 1'b1)
         so_last <= dq_o[1];
      // select reaches the core two edges late through its synchroniser
      cs_hist <= {cs_hist[0], cs_n};
      if (((cs_n === 1'b1 && cs_hist === 2'b11) || read_phase === 1'b0)
          && dq_oe !== 4'h0)
         n_bad <= n_bad + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         complete_run();
      end
   end
   // host-side view of the data lines at each rising serial clock: all four in quad, lines 0 and 1 otherwise
   always @(posedge sck)
   begin
      multi_oe <= dq_oe;
      if (xfer_width == 2'd2)
         multi_got <= {multi_got[3:0], dq_o};
      else
         multi_got <= {multi_got[5:0], dq_o[1:0]};
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   task automatic t_prearm;
      // select already low when reset ends: no edge, so nothing is taken
      sfpi_host_i.frame(1'b1);
      rstn <= 1'b0;
      repeat (2) @(negedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(negedge clk_sys);
      sfpi_host_i.xfer(8'hFF, -1);
      chk({7'h00, armed}, 8'h00);
      chk(n_bv[7:0], 8'h00);
      sfpi_host_i.frame(1'b0);
   endtask : t_prearm
   task automatic t_write;
      sfpi_host_i.frame(1'b1);
      sfpi_host_i.xfer(8'hA5, -1);
      sfpi_host_i.frame(1'b0);
      chk(rx_byte, 8'hA5);
      chk({7'h00, armed}, 8'h01);
      chk(n_bv[7:0], 8'h01);
   endtask : t_write
   task automatic t_protect;
      prog_cmd <= 1'b1;
      protected_hit <= 1'b1;
      sfpi_host_i.wp_n <= 1'b0;
      sfpi_host_i.frame(1'b1);
      sfpi_host_i.xfer(8'h02, -1);
      sfpi_host_i.wp_n <= 1'b1;
      sfpi_host_i.xfer(8'h02, -1);
      sfpi_host_i.frame(1'b0);
      prog_cmd <= 1'b0;
      chk(n_rej[7:0], 8'h01);
   endtask : t_protect
   task automatic t_pause;
      sfpi_host_i.frame(1'b1);
      sfpi_host_i.xfer(8'h96, 3);
      sfpi_host_i.frame(1'b0);
      chk(rx_byte, 8'h96);
   endtask : t_pause
   task automatic t_read;
      int txn0;
      tx_byte <= 8'h3C;
      sfpi_host_i.frame(1'b1);
      sfpi_host_i.xfer(8'h03, -1);
      // data follows the command: first bit leaves on its last clock fall
      read_phase <= 1'b1;
      txn0 = n_txn;
      sfpi_host_i.xfer(8'h00, -1);
      sfpi_host_i.frame(1'b0);
      read_phase <= 1'b0;
      chk(got, 8'h3C);
      chk(8'(n_txn - txn0), 8'h02);
   endtask : t_read
   task automatic t_multi(input logic [1:0] w, input logic [3:0] oe);
      quad_en <= (w == 2'd2);
      tx_byte <= 8'hC3;
      sfpi_host_i.frame(1'b1);
      sfpi_host_i.xfer(8'h6B, -1);
      read_phase <= 1'b1;
      xfer_width <= w;
      sfpi_host_i.xfer(8'h00, -1);
      sfpi_host_i.frame(1'b0);
      read_phase <= 1'b0;
      xfer_width <= 2'd0;
      quad_en <= 1'b0;
      chk(multi_got, 8'hC3);
      chk({4'h0, multi_oe}, {4'h0, oe});
   endtask : t_multi
   task automatic t_standby;
      busy <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk({7'h00, standby}, 8'h00);
      busy <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk({7'h00, standby}, 8'h01);
      chk(n_bad[7:0], 8'h00);
   endtask : t_standby
   initial
   begin
      quad_en       <= 1'b0;
      xfer_width    <= 2'h0;
      busy          <= 1'b0;
      protected_hit <= 1'b0;
      read_phase    <= 1'b0;
      prog_cmd      <= 1'b0;
      tx_byte       <= 8'h00;
      repeat (2) @(negedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(negedge clk_sys);
      t_prearm();
      t_write();
      t_protect();
      t_pause();
      t_read();
      t_multi(2'd1, 4'h3);
      t_multi(2'd2, 4'hF);
      t_standby();
      complete_run();
   end
endmodule : tb_sfpi_core
`default_nettype wire
